// File: hdl/timer_defines.vh
// Register map, field positions and reset values of the overflow timer
// Summary of operation
// - Mode bit zero gives one 16-bit counter
// - Three-bit field picks the count clock
// - Clear-enable set: compare match zeroes counter
// - Clear-enable zero: match leaves counter counting
// - Wrap from all-ones sets overflow flag
// - Overflow cleared by zero write after read
// - Overflow with enable sets request flag
// - Request flag and enable raise interrupt
// - Software reads and writes all counter bits
// - Pin function bit routes pin to event input
// - Event edge select: one rising, zero falling
`ifndef TIMER_DEFINES_VH
`define TIMER_DEFINES_VH

// Byte addresses on the register port
`define ADDR_CTRL       16'hFFB6
`define ADDR_STAT       16'hFFB7
`define ADDR_COUNT_HI   16'hFFB8
`define ADDR_COUNT_LO   16'hFFB9
`define ADDR_CMP_HI     16'hFFBA
`define ADDR_CMP_LO     16'hFFBB
`define ADDR_PIN_FUNC   16'hFFC3
`define ADDR_EDGE_SEL   16'hFFF2
`define ADDR_IRQ_EN     16'hFFF4
`define ADDR_IRQ_REQ    16'hFFF7

// Control register fields
`define CTRL_MODE_BIT   7
`define CTRL_CKS_MSB    2
`define CTRL_CKS_LSB    0
`define CKS_EXT_EVENT   3'h7

// Status register fields
`define STAT_OVF_BIT    7
`define STAT_OVIE_BIT   5
`define STAT_CCLR_BIT   4

// Single-bit fields of the other registers
`define PIN_FUNC_BIT    0
`define EDGE_SEL_BIT    6
`define IRQ_TIMER_BIT   3

// Reset values and prescaler width
`define CTRL_RST        8'h00
`define STAT_RST        1'b0
`define COUNT_RST       16'h0000
`define CMP_RST         16'hFFFF
`define PIN_FUNC_RST    8'h00
`define EDGE_SEL_RST    1'b1
`define IRQ_EN_RST      1'b0
`define PRESCALE_W      12

`endif

// File: hdl/event_edge_detect.v
// Edge detector for the external event input of the timer
`timescale 1ns/10ps
module event_edge_detect
(
  input  wire ref_clk,      // System clock
  input  wire rst,          // Synchronous reset, active high
  input  wire pin_level,    // Shared pin, already synchronous
  input  wire enable,       // Pin routed to the event input
  input  wire rising_sel,   // One for rising, zero for falling
  output reg  edge_pulse_r  // One-cycle pulse per selected edge
);

  reg prev_r;

  ////////////////////////////////////////////////////////////////////////////
  // Previous level tracks always, so a new enable sees no false edge
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      prev_r       <= 1'b0;
      edge_pulse_r <= 1'b0;
    end
    else
    begin
      prev_r <= pin_level;
      if (rising_sel)
        edge_pulse_r <= enable & pin_level & ~prev_r;
      else
        edge_pulse_r <= enable & ~pin_level & prev_r;
    end
  end

endmodule

// File: hdl/overflow_timer.v
// Sixteen-bit timer with compare clear, overflow flag and interrupt chain
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
`include "timer_defines.vh"
module overflow_timer
(
  input  wire        ref_clk,        // System clock, 40 MHz
  input  wire        rst,            // Synchronous reset, active high
  input  wire [15:0] addr,           // Register byte address
  input  wire [7:0]  wdata,          // Write data
  input  wire        wr_en,          // Write strobe, one cycle
  input  wire        rd_en,          // Read strobe, one cycle
  output reg  [7:0]  rdata,          // Read data, cycle after strobe
  input  wire        shared_pin,     // Shared port / serial / event pin
  output reg         port_pin_data,  // Pin level for port or serial use
  output wire        event_selected, // Pin routed to the event input
  output wire        irq             // Level interrupt to the core
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  reg [7:0]               ctrl_r;
  reg                     ovf_r;
  reg                     ovie_r;
  reg                     cclr_r;
  reg                     ovf_seen_r;
  reg [15:0]              count_r;
  reg [15:0]              count_nxt;
  reg [15:0]              cmp_r;
  reg [7:0]               pin_func_r;
  reg                     edge_sel_r;
  reg                     irq_en_r;
  reg                     irq_req_r;
  reg [`PRESCALE_W-1:0]   pre_r;
  reg                     overflow_evt;

  wire [2:0] clk_sel;
  wire       mode_split;
  wire       ext_pulse;
  wire       tick;
  wire       wr_ctrl;
  wire       wr_stat;
  wire       wr_cnt_hi;
  wire       wr_cnt_lo;
  wire       wr_cmp_hi;
  wire       wr_cmp_lo;
  wire       wr_pin;
  wire       wr_edge;
  wire       wr_ien;
  wire       wr_irr;
  wire       cmp_match;
  wire [7:0] stat_view;

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler tick: code n divides the system clock by 4 to the n
  function prescale_tick;
    input [2:0]             code;
    input [`PRESCALE_W-1:0] pre;
    reg   [`PRESCALE_W-1:0] mask;
    begin
      mask          = ~({`PRESCALE_W{1'b1}} << {code, 1'b0});
      prescale_tick = &(pre | ~mask);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Write decode
  assign wr_ctrl   = wr_en & (addr == `ADDR_CTRL);
  assign wr_stat   = wr_en & (addr == `ADDR_STAT);
  assign wr_cnt_hi = wr_en & (addr == `ADDR_COUNT_HI);
  assign wr_cnt_lo = wr_en & (addr == `ADDR_COUNT_LO);
  assign wr_cmp_hi = wr_en & (addr == `ADDR_CMP_HI);
  assign wr_cmp_lo = wr_en & (addr == `ADDR_CMP_LO);
  assign wr_pin    = wr_en & (addr == `ADDR_PIN_FUNC);
  assign wr_edge   = wr_en & (addr == `ADDR_EDGE_SEL);
  assign wr_ien    = wr_en & (addr == `ADDR_IRQ_EN);
  assign wr_irr    = wr_en & (addr == `ADDR_IRQ_REQ);

  assign clk_sel    = ctrl_r[`CTRL_CKS_MSB:`CTRL_CKS_LSB];
  assign mode_split = ctrl_r[`CTRL_MODE_BIT];
  assign stat_view  = {ovf_r, 1'b0, ovie_r, cclr_r, 4'h0};

  ////////////////////////////////////////////////////////////////////////////
  // Pin function switch
  assign event_selected = pin_func_r[`PIN_FUNC_BIT];

  // Port and serial side see the pin only while not claimed by the timer
  always @(posedge ref_clk)
  begin
    if (rst)
      port_pin_data <= 1'b0;
    else
      port_pin_data <= shared_pin & ~event_selected;
  end

  event_edge_detect u_edge
  (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .pin_level    (shared_pin),
    .enable       (event_selected),
    .rising_sel   (edge_sel_r),
    .edge_pulse_r (ext_pulse)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Free-running prescaler for the internal count clocks
  always @(posedge ref_clk)
  begin
    if (rst)
      pre_r <= {`PRESCALE_W{1'b0}};
    else
      pre_r <= pre_r + 1'b1;
  end

  // Count enable; split mode is not provided, so the counter holds there
  assign tick = ~mode_split &
                ((clk_sel == `CKS_EXT_EVENT) ? ext_pulse :
                 prescale_tick(clk_sel, pre_r));

  assign cmp_match = (count_r == cmp_r);

  ////////////////////////////////////////////////////////////////////////////
  // Next count: software write beats compare clear beats increment
  always @*
  begin
    count_nxt    = count_r;
    overflow_evt = 1'b0;
    if (wr_cnt_hi | wr_cnt_lo)
    begin
      if (wr_cnt_hi)
        count_nxt[15:8] = wdata;
      if (wr_cnt_lo)
        count_nxt[7:0]  = wdata;
    end
    else if (tick)
    begin
      if (cclr_r & cmp_match)
        count_nxt = 16'h0000;
      else
      begin
        count_nxt    = count_r + 16'h0001;
        overflow_evt = (count_r == 16'hFFFF);
      end
    end
  end

  always @(posedge ref_clk)
  begin
    if (rst)
      count_r <= `COUNT_RST;
    else
      count_r <= count_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control, compare, pin function, edge select and enable registers
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      ctrl_r     <= `CTRL_RST;
      cmp_r      <= `CMP_RST;
      pin_func_r <= `PIN_FUNC_RST;
      edge_sel_r <= `EDGE_SEL_RST;
      irq_en_r   <= `IRQ_EN_RST;
      ovie_r     <= `STAT_RST >> `STAT_OVIE_BIT;
      cclr_r     <= `STAT_RST >> `STAT_CCLR_BIT;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_r <= wdata;
      if (wr_cmp_hi)
        cmp_r[15:8] <= wdata;
      if (wr_cmp_lo)
        cmp_r[7:0] <= wdata;
      if (wr_pin)
        pin_func_r <= wdata;
      if (wr_edge)
        edge_sel_r <= wdata[`EDGE_SEL_BIT];
      if (wr_ien)
        irq_en_r <= wdata[`IRQ_TIMER_BIT];
      if (wr_stat)
      begin
        ovie_r <= wdata[`STAT_OVIE_BIT];
        cclr_r <= wdata[`STAT_CCLR_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Overflow flag; a clear only counts after the flag was seen set,
  // which stops a blind zero write from losing an unseen overflow
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      ovf_r      <= 1'b0;
      ovf_seen_r <= 1'b0;
    end
    else
    begin
      if (overflow_evt)
        ovf_r <= 1'b1;
      else if (wr_stat & ~wdata[`STAT_OVF_BIT] & ovf_seen_r)
        ovf_r <= 1'b0;
      if (rd_en & (addr == `ADDR_STAT) & ovf_r)
        ovf_seen_r <= 1'b1;
      else if (wr_stat & ~wdata[`STAT_OVF_BIT])
        ovf_seen_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt request flag; a set in the clearing cycle wins
  always @(posedge ref_clk)
  begin
    if (rst)
      irq_req_r <= 1'b0;
    else if (overflow_evt & ovie_r)
      irq_req_r <= 1'b1;
    else if (wr_irr & ~wdata[`IRQ_TIMER_BIT])
      irq_req_r <= 1'b0;
  end

  // Level request to the core, both stages gated
  assign irq = irq_req_r & irq_en_r;

  ////////////////////////////////////////////////////////////////////////////
  // Read data, registered, zero for unmapped addresses
  always @(posedge ref_clk)
  begin
    if (rst)
      rdata <= 8'h00;
    else if (rd_en)
    begin
      case (addr)
        `ADDR_CTRL:     rdata <= ctrl_r;
        `ADDR_STAT:     rdata <= stat_view;
        `ADDR_COUNT_HI: rdata <= count_r[15:8];
        `ADDR_COUNT_LO: rdata <= count_r[7:0];
        `ADDR_CMP_HI:   rdata <= cmp_r[15:8];
        `ADDR_CMP_LO:   rdata <= cmp_r[7:0];
        `ADDR_PIN_FUNC: rdata <= pin_func_r;
        `ADDR_EDGE_SEL: rdata <= {1'b0, edge_sel_r, 6'h00};
        `ADDR_IRQ_EN:   rdata <= {4'h0, irq_en_r, 3'h0};
        `ADDR_IRQ_REQ:  rdata <= {4'h0, irq_req_r, 3'h0};
        default:        rdata <= 8'h00;
      endcase
    end
    else
      rdata <= 8'h00;
  end

endmodule

// File: tb/overflow_timer_properties.sv
// Port assertions for the overflow timer
`timescale 1ns/10ps
module overflow_timer_properties
(
  input wire        ref_clk,        // Clock
  input wire        rst,            // Reset
  input wire [15:0] addr,           // Address
  input wire [7:0]  wdata,          // Write data
  input wire        wr_en,          // Write strobe
  input wire        rd_en,          // Read strobe
  input wire [7:0]  rdata,          // Read data
  input wire        shared_pin,     // Pin
  input wire        port_pin_data,  // Port copy
  input wire        event_selected, // Event route
  input wire        irq             // Interrupt
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Decoded writes
  wire wr_pf = wr_en && addr == 16'hFFC3;
  wire wr_ir = wr_en && (addr == 16'hFFF4 || addr == 16'hFFF7);
  ////////////////////////////////////////////////////////////
  // Bus and pin routing
  chk_rdata_idle: assert property (!$past(rd_en) |-> rdata == 8'h00)
    else $error("rdata not idle");
  chk_pf_write: assert property (wr_pf |=> event_selected == $past(wdata[0]))
    else $error("pin route not written");
  chk_pf_hold: assert property (!wr_pf |=> $stable(event_selected))
    else $error("pin route changed");
  chk_pf_read: assert property (rd_en && addr == 16'hFFC3 |=> rdata[0] == $past(event_selected))
    else $error("pin route readback");
  chk_port_forced: assert property (event_selected [*2] |-> !port_pin_data)
    else $error("port data not forced");
  // Interrupt chain
  chk_irq_mask: assert property (wr_en && addr == 16'hFFF4 && !wdata[3] |=> !irq)
    else $error("irq not masked");
  chk_irq_hold: assert property (irq && !wr_ir |=> irq)
    else $error("irq dropped");
  chk_irq_rise: assert property ($rose(irq) |-> !$past(rst))
    else $error("irq after reset");
  cover property ($rose(irq));
  cover property ($fell(irq));
  cover property (wr_pf && wdata[0]);
endmodule
bind overflow_timer overflow_timer_properties chk (.ref_clk(ref_clk), .rst(rst), .addr(addr),
  .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .shared_pin(shared_pin),
  .port_pin_data(port_pin_data), .event_selected(event_selected), .irq(irq));

// File: tb/event_source.sv
// Model of the outside pulse source on the shared pin
`timescale 1ns/10ps
module event_source
(
  input wire ref_clk, // System clock
  output reg pin      // Shared pin level
);
  initial pin = 1'b0;
  // Levels held four cycles so each edge is seen once
  task pulses(input integer n);
    repeat (n)
    begin
      level(1'b1);
      repeat (3) @(posedge ref_clk);
      level(1'b0);
      repeat (3) @(posedge ref_clk);
    end
  endtask
  task level(input bit v);
    @(posedge ref_clk) pin <= v;
  endtask
endmodule

// File: tb/sixteen_bit_timer_overflow_irq_tb.sv
// Self-checking bench for the overflow timer
`timescale 1ns/10ps
module sixteen_bit_timer_overflow_irq_tb;
  logic ref_clk = 0, rst = 1, wr_en = 0, rd_en = 0;
  logic [15:0] addr = 0;
  logic [7:0] wdata = 0, rdata, v, d, m, e;
  logic a_w;
  logic [15:0] a;
  wire pin, port_pin_data, event_selected, irq;
  integer n_errors = 0, total_checks = 0, i, c;
  // Rows: address, write flag, write data, read mask, expected
  logic [40:0] rows [0:14] = '{
    {16'hFFB6, 1'b0, 8'h00, 8'hFF, 8'h00}, {16'hFFB7, 1'b0, 8'h00, 8'hFF, 8'h00},
    {16'hFFBA, 1'b0, 8'h00, 8'hFF, 8'hFF}, {16'hFFBB, 1'b0, 8'h00, 8'hFF, 8'hFF},
    {16'hFFF2, 1'b0, 8'h00, 8'h40, 8'h40}, {16'hFFF4, 1'b0, 8'h00, 8'h08, 8'h00},
    {16'hFFF7, 1'b0, 8'h00, 8'h08, 8'h00}, {16'hFFC3, 1'b0, 8'h00, 8'h01, 8'h00},
    {16'hFFB6, 1'b1, 8'h80, 8'hFF, 8'h80}, {16'hFFB8, 1'b1, 8'h12, 8'hFF, 8'h12},
    {16'hFFB9, 1'b1, 8'h34, 8'hFF, 8'h34}, {16'hFFBB, 1'b1, 8'h78, 8'hFF, 8'h78},
    {16'hFFF2, 1'b1, 8'h00, 8'h40, 8'h00}, {16'hFFF4, 1'b1, 8'h08, 8'h08, 8'h08},
    {16'h0000, 1'b1, 8'h5A, 8'hFF, 8'h00}};
  ////////////////////////////////////////////////////////////
  // Clock, design and pin source
  always #12.5 ref_clk = ~ref_clk;
  overflow_timer dut (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .shared_pin(pin),
    .port_pin_data(port_pin_data), .event_selected(event_selected), .irq(irq));
  event_source ev (.ref_clk(ref_clk), .pin(pin));
  ////////////////////////////////////////////////////////////
  // Bus tasks; strobes drop after their edge
  task wr(input [15:0] ad, input [7:0] dt);
    addr <= ad;
    wdata <= dt;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask
  task cmp(input string s, input [15:0] ad, input [7:0] ex, input [7:0] got);
    total_checks = total_checks + 1;
    if (got !== ex)
    begin
      n_errors = n_errors + 1;
      $display("ERROR %s %h expected %h seen %h", s, ad, ex, got);
    end
  endtask
  // Read data is taken mid-cycle while it stands, clear of the edge race
  task chk(input [15:0] ad, input [7:0] mk, input [7:0] ex);
    addr <= ad;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    @(negedge ref_clk);
    cmp("reg", ad, ex, rdata & mk);
    @(posedge ref_clk);
  endtask
  // Pin outputs are looked at mid-cycle, once settled
  task look(input string s, input [15:0] tg, input [7:0] ex, input sel);
    @(negedge ref_clk);
    if (sel)
      cmp(s, tg, ex, {7'h00, irq});
    else
      cmp(s, tg, ex, {7'h00, port_pin_data});
    @(posedge ref_clk);
  endtask
  task final_report;
    if (n_errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // Watchdog; whole run needs far fewer cycles
  initial
  begin
    #(25 * 20000);
    n_errors = n_errors + 1;
    final_report;
  end
  // Main sequence
  initial
  begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    for (i = 0; i < 15; i = i + 1)
    begin
      {a, a_w, d, m, e} = rows[i];
      if (a_w)
        wr(a, d);
      chk(a, m, e);
    end
    // Six ticks carry the count across the wrap
    wr(16'hFFB8, 8'hFF);
    wr(16'hFFB9, 8'hFD);
    wr(16'hFFB7, 8'h20);
    wr(16'hFFB6, 8'h00);
    repeat (5) @(posedge ref_clk);
    wr(16'hFFB6, 8'h80);
    chk(16'hFFB9, 8'hFF, 8'h03);
    chk(16'hFFB7, 8'hFF, 8'hA0);
    chk(16'hFFF7, 8'h08, 8'h08);
    look("irq", 0, 8'h01, 1'b1);
    wr(16'hFFB7, 8'hA0);
    chk(16'hFFB7, 8'hFF, 8'hA0);
    wr(16'hFFB7, 8'h20);
    chk(16'hFFB7, 8'hFF, 8'h20);
    wr(16'hFFF4, 8'h00);
    look("irq", 1, 8'h00, 1'b1);
    wr(16'hFFF4, 8'h08);
    look("irq", 2, 8'h01, 1'b1);
    wr(16'hFFF7, 8'h00);
    look("irq", 3, 8'h00, 1'b1);
    // Nine ticks against a compare value of five
    for (c = 0; c < 2; c = c + 1)
    begin
      wr(16'hFFB9, 8'h00);
      wr(16'hFFBA, 8'h00);
      wr(16'hFFBB, 8'h05);
      wr(16'hFFB7, c ? 8'h10 : 8'h00);
      wr(16'hFFB6, 8'h00);
      repeat (8) @(posedge ref_clk);
      wr(16'hFFB6, 8'h80);
      chk(16'hFFB9, 8'hFF, c ? 8'h03 : 8'h09);
    end
    // Pin events: three pulses then a final rise
    for (c = 0; c < 2; c = c + 1)
    begin
      wr(16'hFFB6, 8'h87);
      wr(16'hFFB9, 8'h00);
      wr(16'hFFF2, c ? 8'h40 : 8'h00);
      wr(16'hFFC3, 8'h01);
      wr(16'hFFB6, 8'h07);
      ev.pulses(3);
      ev.level(1'b1);
      repeat (4) @(posedge ref_clk);
      look("port", 4, 8'h00, 1'b0);
      wr(16'hFFB6, 8'h87);
      chk(16'hFFB9, 8'hFF, c ? 8'h04 : 8'h03);
      ev.level(1'b0);
    end
    wr(16'hFFC3, 8'h00);
    ev.level(1'b1);
    repeat (3) @(posedge ref_clk);
    look("port", 5, 8'h01, 1'b0);
    final_report;
  end
endmodule
